// ### imap_pkg.sv
// Purpose: Constants for the indirect memory access register bank
// Assumes: Avalon-MM word addressing, 32-bit data, 8-bit registers in the low byte
// Notes:   Times are given in reference clock periods; single-access times doubled to keep the halves
package imap_pkg;

    // ------------------------------------------------------------------
    // Register map (word index on the Avalon address)
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_ACCESS_DATA    = 3'h0;
    localparam logic [2:0] REG_ACCESS_ADDRESS = 3'h1;
    localparam logic [2:0] REG_ACCESS_CONTROL = 3'h2;
    localparam logic [2:0] REG_OPERATION_MODE = 3'h3;
    localparam logic [2:0] REG_STATUS         = 3'h4;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         ADDR_DIR_BIT      = 7;
    localparam int         CTRL_RWS_BIT      = 7;
    localparam int         CTRL_OPC_LSB      = 3;
    localparam int         MODE_SEL_LSB      = 6;
    localparam int         STATUS_BUSY_BIT   = 0;
    localparam logic [7:0] OPERATION_MODE_RST = 8'h00;
    localparam logic [7:0] ACCESS_REG_RST    = 8'h00;

    // ------------------------------------------------------------------
    // Access modes and operation codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_CM_RESET = 2'h0;
    localparam logic [1:0] MODE_TEST     = 2'h1;
    localparam logic [1:0] MODE_CM_INIT  = 2'h2;
    localparam logic [1:0] MODE_NORMAL   = 2'h3;
    localparam logic [3:0] OPC_NONE      = 4'h0;
    localparam logic [3:0] OPC_CM_DATA   = 4'h9;
    localparam logic [3:0] OPC_TRI_ONE   = 4'hc;
    localparam logic [3:0] OPC_TRI_ALL   = 4'hd;
    localparam logic [2:0] OPC_CM_FULL   = 3'h7;

    // ------------------------------------------------------------------
    // Clock rates in hertz, and timing in reference clock periods
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ       = 40_000_000;
    localparam int REF_CLK_HZ       = 4_000_000;
    localparam int ACC_NORMAL_X2    = 19;
    localparam int ACC_INIT_X2      = 5;
    localparam int ACC_CM_RESET     = 256;
    localparam int ACC_TRI_ALL      = 1035;
    localparam int ACC_SWEEP        = 256;
    localparam int ACC_NORMAL_TICKS = ACC_NORMAL_X2 / 2;
    localparam int ACC_INIT_TICKS   = ACC_INIT_X2 / 2;
    localparam int LEN_W            = 11;

endpackage

// ### imap_top.sv
// Purpose: Indirect access to control and data memories over Avalon-MM
// Assumes: One clock; the reference clock is a divided enable pulse
// Notes:   Slave answers every request on the second cycle
`timescale 1ns/10ps

// What this block does
// - Data register carries value moved; tristate fields use only its low 4 bits.
// - Address bit 7 picks upstream or downstream; bits 6-0 give port and timeslot.
// - Control register picks memory, field, read or write, plus 4-bit function code.
// - Control write starts operation; busy reads 1 while running, 0 when done.
// - Operations run on reference clock; single access ends within 9.5 cycles.
// - Two-bit mode field selects reset, initialisation, normal or test mode.
// - Mode 00 full write fills whole control memory in 256 reference cycles.
// - Control-memory reset mode keeps both serial interfaces stopped.
// - Mode 10 accesses one address within 2.5 cycles; interfaces suspended.
// - Mode 11 runs interfaces; single access within 9.5 cycles, tristate fill 1035.
// - Mode 01 keeps running but applies accesses to every location, ignoring address.
// - Upstream data memory value is resent each frame as idle code.
// - Upstream data writes transfer only the bits chosen by operation code.
// - Upstream data writes force the direction bit to upstream.
// - Downstream data memory is read-only and shows received timeslot contents.
// - Control value 80 hex reads data memory; all 8 bits return.
// - Code 1100 exchanges one tristate field; 1101 fills all of them.
module imap_top #(
    parameter int RCL_DIV = imap_pkg::SYS_CLK_HZ / imap_pkg::REF_CLK_HZ
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [2:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        pcm_rx_valid_i,
    input  wire logic [6:0]  pcm_rx_slot_i,
    input  wire logic [7:0]  pcm_rx_data_i,
    input  wire logic [6:0]  pcm_tx_slot_i,
    output logic      [7:0]  pcm_tx_data_o,
    output logic      [3:0]  pcm_tx_lowz_o,
    input  wire logic [7:0]  cfi_slot_i,
    output logic      [7:0]  cfi_cm_data_o,
    output logic      [3:0]  cfi_cm_code_o,
    output logic             cfi_run_o,
    output logic             pcm_run_o
);

    // ------------------------------------------------------------------
    // Reset release and reference clock enable
    // ------------------------------------------------------------------
    logic       rst_q1;
    logic       rst_n;
    logic [7:0] div_cnt;
    logic       tick;

    // Release of the asynchronous reset through two flops
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Divider giving one reference clock enable per RCL_DIV cycles
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == 8'(RCL_DIV - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign tick = (div_cnt == 8'(RCL_DIV - 1));

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    logic [7:0] access_data;
    logic [7:0] access_address;
    logic [7:0] access_control;
    logic [7:0] operation_mode;
    logic       memory_busy_flag;
    logic       req;
    logic       wr_take;
    logic       wr_lo;
    logic [7:0] wdata;
    logic [7:0] rd_mux;
    logic       wr_data;
    logic       wr_addr;
    logic       wr_ctrl;
    logic       wr_mode;

    // Request taken at the edge where waitrequest is low
    assign req     = avs_read_i | avs_write_i;
    assign wr_take = avs_write_i & ~avs_waitrequest_o;
    assign wr_lo   = wr_take & avs_byteenable_i[0];
    assign wdata   = avs_writedata_i[7:0];
    // Access registers are frozen while an operation runs
    assign wr_data = wr_lo & ~memory_busy_flag & (avs_address_i == imap_pkg::REG_ACCESS_DATA);
    assign wr_addr = wr_lo & ~memory_busy_flag & (avs_address_i == imap_pkg::REG_ACCESS_ADDRESS);
    assign wr_ctrl = wr_lo & ~memory_busy_flag & (avs_address_i == imap_pkg::REG_ACCESS_CONTROL);
    assign wr_mode = wr_lo & (avs_address_i == imap_pkg::REG_OPERATION_MODE);

    // Read selection; unmapped words read zero
    always_comb begin
        unique case (avs_address_i)
            imap_pkg::REG_ACCESS_DATA:    rd_mux = access_data;
            imap_pkg::REG_ACCESS_ADDRESS: rd_mux = access_address;
            imap_pkg::REG_ACCESS_CONTROL: rd_mux = access_control;
            imap_pkg::REG_OPERATION_MODE: rd_mux = operation_mode;
            imap_pkg::REG_STATUS:         rd_mux = {7'h00, memory_busy_flag};
            default:                      rd_mux = 8'h00;
        endcase
    end

    // One wait cycle per request, read data captured at the same time
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
            if (avs_read_i & avs_waitrequest_o) begin
                avs_readdata_o <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic [3:0] opc;
    logic [1:0] mode;
    logic       rd_op;
    logic       cm_full;
    logic       cm_dat;
    logic       tri_one;
    logic       tri_all;
    logic       dm_dat;
    logic       sweep;
    logic [imap_pkg::LEN_W-1:0] op_len;

    assign opc     = access_control[imap_pkg::CTRL_OPC_LSB +: 4];
    assign rd_op   = access_control[imap_pkg::CTRL_RWS_BIT];
    assign mode    = operation_mode[imap_pkg::MODE_SEL_LSB +: 2];
    assign cm_full = (opc[3:1] == imap_pkg::OPC_CM_FULL);
    assign cm_dat  = (opc == imap_pkg::OPC_CM_DATA);
    assign tri_one = (opc == imap_pkg::OPC_TRI_ONE);
    assign tri_all = (opc == imap_pkg::OPC_TRI_ALL);
    assign dm_dat  = ~opc[3];
    // Whole-memory sweeps ignore the address register
    assign sweep   = (mode == imap_pkg::MODE_TEST) | tri_all
                   | ((mode == imap_pkg::MODE_CM_RESET) & cm_full & ~rd_op);

    // Length of an operation in reference clock periods
    always_comb begin
        if (tri_all) begin
            op_len = imap_pkg::LEN_W'(imap_pkg::ACC_TRI_ALL);
        end else if (sweep & (mode == imap_pkg::MODE_CM_RESET)) begin
            op_len = imap_pkg::LEN_W'(imap_pkg::ACC_CM_RESET);
        end else if (sweep) begin
            op_len = imap_pkg::LEN_W'(imap_pkg::ACC_SWEEP);
        end else if (mode == imap_pkg::MODE_CM_INIT) begin
            op_len = imap_pkg::LEN_W'(imap_pkg::ACC_INIT_TICKS);
        end else begin
            op_len = imap_pkg::LEN_W'(imap_pkg::ACC_NORMAL_TICKS);
        end
    end

    // Sub-timeslot mask of an upstream data write
    function automatic logic [7:0] opc_mask(input logic [3:0] code);
        unique case (code)
            4'h1:    opc_mask = 8'hff;
            4'h3:    opc_mask = 8'hf0;
            4'h2:    opc_mask = 8'h0f;
            4'h7:    opc_mask = 8'hc0;
            4'h6:    opc_mask = 8'h30;
            4'h5:    opc_mask = 8'h0c;
            4'h4:    opc_mask = 8'h03;
            default: opc_mask = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IMAP_IDLE = 2'b01,
        IMAP_RUN  = 2'b10
    } imap_state_t;

    imap_state_t                state;
    logic [imap_pkg::LEN_W-1:0] tick_cnt;
    logic                       act;
    logic                       last;
    logic [7:0]                 loc;
    logic [7:0]                 rd_hold;
    logic [7:0]                 rd_val;

    // One memory action per tick for the first 256 ticks of a sweep, or one at the first tick
    assign act  = (state == IMAP_RUN) & tick
                & (sweep ? (tick_cnt < imap_pkg::LEN_W'(imap_pkg::ACC_SWEEP))
                         : (tick_cnt == '0));
    assign last = (state == IMAP_RUN) & tick & (tick_cnt == op_len - 1'b1);
    assign loc  = sweep ? tick_cnt[7:0] : access_address;

    // Control write starts, final tick ends the operation
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state            <= IMAP_IDLE;
            tick_cnt         <= '0;
            memory_busy_flag <= 1'b0;
        end else begin
            unique case (state)
                IMAP_IDLE: begin
                    tick_cnt <= '0;
                    if (wr_ctrl) begin
                        state            <= IMAP_RUN;
                        memory_busy_flag <= 1'b1;
                    end
                end
                IMAP_RUN: begin
                    if (last) begin
                        state            <= IMAP_IDLE;
                        memory_busy_flag <= 1'b0;
                    end else if (tick) begin
                        tick_cnt <= tick_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Access registers
    // ------------------------------------------------------------------
    // Host writes, and read results loaded on the final tick
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            access_data    <= imap_pkg::ACCESS_REG_RST;
            access_address <= imap_pkg::ACCESS_REG_RST;
            access_control <= imap_pkg::ACCESS_REG_RST;
            operation_mode <= imap_pkg::OPERATION_MODE_RST;
        end else begin
            if (wr_data) begin
                access_data <= wdata;
            end else if (last & rd_op) begin
                access_data <= rd_hold;
            end
            if (wr_addr) begin
                access_address <= wdata;
            end
            if (wr_ctrl) begin
                access_control <= wdata;
            end
            if (wr_mode) begin
                operation_mode <= wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------------
    logic [7:0] cm_data_mem [256];
    logic [3:0] cm_code_mem [256];
    logic [7:0] dm_up_mem   [128];
    logic [3:0] dm_tri_mem  [128];
    logic [7:0] dm_down_mem [128];
    logic [7:0] wmask;
    logic [6:0] dm_loc;

    assign wmask  = opc_mask(opc);
    assign dm_loc = loc[6:0];

    // Value a single read returns
    always_comb begin
        if (cm_full | cm_dat) begin
            rd_val = cm_data_mem[loc];
        end else if (tri_one | tri_all) begin
            rd_val = {4'h0, dm_tri_mem[dm_loc]};
        end else if (loc[imap_pkg::ADDR_DIR_BIT]) begin
            rd_val = dm_up_mem[dm_loc];
        end else begin
            rd_val = dm_down_mem[dm_loc];
        end
    end

    // Writes from commands; upstream data is always the upstream block
    always_ff @(posedge clk_sys_i) begin
        if (act & ~rd_op & (cm_full | cm_dat)) begin
            cm_data_mem[loc] <= access_data;
        end
        if (act & ~rd_op & cm_full) begin
            cm_code_mem[loc] <= {access_control[3], access_control[2:0]};
        end
        if (act & ~rd_op & dm_dat) begin
            dm_up_mem[dm_loc] <= (dm_up_mem[dm_loc] & ~wmask)
                               | (access_data & wmask);
        end
        if (act & ~rd_op & (tri_one | tri_all)) begin
            dm_tri_mem[dm_loc] <= access_data[3:0];
        end
        if (pcm_rx_valid_i) begin
            dm_down_mem[pcm_rx_slot_i] <= pcm_rx_data_i;
        end
    end

    // Read result held until it is loaded into the data register
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_hold <= 8'h00;
        end else if (act & rd_op) begin
            rd_hold <= rd_val;
        end
    end

    // ------------------------------------------------------------------
    // Interface side
    // ------------------------------------------------------------------
    logic run;

    // Interfaces run only in normal and test modes
    assign run = (mode == imap_pkg::MODE_NORMAL) | (mode == imap_pkg::MODE_TEST);

    // Transmit and switching reads, repeated every frame
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pcm_tx_data_o <= 8'h00;
            pcm_tx_lowz_o <= 4'h0;
            cfi_cm_data_o <= 8'h00;
            cfi_cm_code_o <= 4'h0;
            cfi_run_o     <= 1'b0;
            pcm_run_o     <= 1'b0;
        end else begin
            pcm_tx_data_o <= dm_up_mem[pcm_tx_slot_i];
            pcm_tx_lowz_o <= run ? dm_tri_mem[pcm_tx_slot_i] : 4'h0;
            cfi_cm_data_o <= cfi_cm_data_mem_rd(cfi_slot_i);
            cfi_cm_code_o <= run ? cm_code_mem[cfi_slot_i] : 4'h0;
            cfi_run_o     <= run;
            pcm_run_o     <= run;
        end
    end

    // Control memory data lookup for the switching side
    function automatic logic [7:0] cfi_cm_data_mem_rd(input logic [7:0] idx);
        cfi_cm_data_mem_rd = cm_data_mem[idx];
    endfunction

endmodule

// ### imap_assertions.sv
// Purpose: Bus and run-state checks for the memory access block
// Assumes: Sees the top module ports only
// Notes:   Bound to imap_top at the foot of this file
`timescale 1ns/10ps
module imap_checker (
    input wire logic        clk_sys_i,
    input wire logic        rstn_i,
    input wire logic [2:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [3:0]  pcm_tx_lowz_o,
    input wire logic [3:0]  cfi_cm_code_o,
    input wire logic        cfi_run_o,
    input wire logic        pcm_run_o
);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // A fresh request, and an accepted write of the mode register
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_mode_wr;
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
            && avs_address_i == imap_pkg::REG_OPERATION_MODE;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_wait_answer: assert property (s_req |=> !avs_waitrequest_o)
        else $error("no answer to a request");
    chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    chk_read_byte: assert property (avs_read_i && !avs_waitrequest_o
            |-> avs_readdata_o[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    chk_data_stands: assert property ($changed(avs_readdata_o)
            |-> avs_read_i && !avs_waitrequest_o)
        else $error("read data changed outside a read");
    chk_mode_run: assert property (s_mode_wr
            |=> ##1 cfi_run_o == $past(avs_writedata_i[6], 2))
        else $error("run level not following mode");
    chk_run_pair: assert property (cfi_run_o == pcm_run_o)
        else $error("interfaces disagree on running");
    chk_idle_quiet: assert property (!cfi_run_o && !$past(cfi_run_o)
            |-> cfi_cm_code_o == 4'h0 && pcm_tx_lowz_o == 4'h0)
        else $error("outputs active while stopped");
endmodule

bind imap_top imap_checker u_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pcm_tx_lowz_o(pcm_tx_lowz_o), .cfi_cm_code_o(cfi_cm_code_o),
    .cfi_run_o(cfi_run_o), .pcm_run_o(pcm_run_o)
);

// ### imap_host.sv
// Purpose: Host processor model on the register bus
// Assumes: Avalon-MM slave with waitrequest
// Notes:   put and get are raw cycles; op keeps the access order
`timescale 1ns/10ps
module imap_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        wait_i,
    output logic      [2:0]  adr_o = 3'h0,
    output logic             rd_o = 1'b0,
    output logic             wr_o = 1'b0,
    output logic      [31:0] wd_o = 32'h0,
    output logic             note_o = 1'b0
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // One request, held until waitrequest is seen low at an edge
    task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
                        input logic chk, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_o <= a;
        wd_o <= {24'h0, d};
        rd_o <= !w;
        wr_o <= w;
        note_o <= chk;
        do begin
            @(posedge clk_i);
            n++;
        end while (wait_i !== 1'b0 && n < 64);
        q = rdata_i[7:0];
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        note_o <= 1'b0;
    endtask
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, 1'b0, q);
    endtask
    task automatic get(input logic [2:0] a, input logic chk);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, chk, q);
    endtask
    // Polls the busy flag until it reads clear
    task automatic idle;
        logic [7:0] s;
        int n;
        n = 0;
        do begin
            xfer(1'b0, imap_pkg::REG_STATUS, 8'h00, 1'b0, s);
            n++;
        end while (s[imap_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 2000);
    endtask
    // Data, address, then control, once the previous operation is over
    task automatic op(input logic wd, input logic [7:0] d, a, c);
        idle();
        if (wd) begin
            put(imap_pkg::REG_ACCESS_DATA, d);
        end
        put(imap_pkg::REG_ACCESS_ADDRESS, a);
        put(imap_pkg::REG_ACCESS_CONTROL, c);
    endtask
endmodule

// ### test_indirect_memory_access.sv
// Purpose: Self-checking bench for the memory access block
// Assumes: Reference tick every DIV clocks
// Notes:   Reads and port lookups are checked from queues
`timescale 1ns/10ps
module test_indirect_memory_access;
    localparam int DIV = 2;
    logic        clk;
    logic        rstn = 1'b0;
    logic [2:0]  adr;
    logic        rd, wr, wreq, note, crun, prun;
    logic [31:0] wd, rdata, g;
    logic        rx_v = 1'b0;
    logic [6:0]  rx_s = 7'h0, tx_s = 7'h0;
    logic [7:0]  rx_d = 8'h0;
    logic [7:0]  cfi_s = 8'h0;
    logic [7:0]  tx_d, cm_d, d, a, v, c, s, e;
    logic [3:0]  lowz, cm_c;
    logic        lk = 1'b0;
    logic [9:0]  ln;
    logic [31:0] rq[$];
    logic [9:0]  lq[$];
    logic [3:0]  oc[8] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4};
    logic [7:0]  mk[8] = '{8'h00, 8'hff, 8'hf0, 8'h0f, 8'hc0, 8'h30, 8'h0c, 8'h03};
    int          t0, mismatches = 0, compares = 0, cyc = 0;
    string       nm;

    imap_top #(.RCL_DIV(DIV)) uut (
        .clk_sys_i(clk), .rstn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pcm_rx_valid_i(rx_v),
        .pcm_rx_slot_i(rx_s), .pcm_rx_data_i(rx_d), .pcm_tx_slot_i(tx_s),
        .pcm_tx_data_o(tx_d), .pcm_tx_lowz_o(lowz), .cfi_slot_i(cfi_s),
        .cfi_cm_data_o(cm_d), .cfi_cm_code_o(cm_c), .cfi_run_o(crun), .pcm_run_o(prun)
    );
    imap_host host (
        .clk_i(clk), .rdata_i(rdata), .wait_i(wreq), .adr_o(adr), .rd_o(rd),
        .wr_o(wr), .wd_o(wd), .note_o(note)
    );
    // ----------------------------------------
    // Checking tasks
    // ----------------------------------------
    task automatic cmp_val(input string n, input logic [31:0] ex, got);
        compares++;
        if (ex !== got) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, ex, got);
        end
    endtask
    task automatic cmp_time(input int n, input int got);
        compares++;
        if (got < (n - 1) * DIV + 1 || got > n * DIV + 8) begin
            mismatches++;
            $display("unexpected busy time: expected %0d ticks, seen %0d clocks", n, got);
        end
    endtask
    task automatic chk_rd(input logic [2:0] ra, input logic [31:0] ex);
        rq.push_back(ex);
        host.get(ra, 1'b1);
    endtask
    // Presents a slot to both interfaces; the output shows one cycle later
    task automatic look(input logic [7:0] sl, input logic [1:0] k, input logic [7:0] ex);
        @(posedge clk);
        tx_s <= sl[6:0];
        cfi_s <= sl;
        @(posedge clk);
        lq.push_back({k, ex});
        lk <= 1'b1;
        @(posedge clk);
        lk <= 1'b0;
    endtask
    task automatic run(input logic w, input logic [7:0] dv, av, cv, input int n);
        host.op(w, dv, av, cv);
        t0 = cyc;
        host.idle();
        cmp_time(n, cyc - t0);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and result monitor
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    // Takes the oldest note whenever a read or a lookup result appears
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (note && rd && !wreq && rq.size() > 0) cmp_val("readdata", rq.pop_front(), rdata);
        if (lk && lq.size() > 0) begin
            ln = lq.pop_front();
            case (ln[9:8])
                2'd0: begin nm = "tx data"; g = {24'h0, tx_d}; end
                2'd1: begin nm = "tristate"; g = {28'h0, lowz}; end
                2'd2: begin nm = "cm data"; g = {24'h0, cm_d}; end
                default: begin nm = "cm code"; g = {28'h0, cm_c}; end
            endcase
            cmp_val(nm, {24'h0, ln[7:0]}, g);
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h8550));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) chk_rd(i[2:0], 32'h0);
        host.put(3'h6, 8'hff);
        chk_rd(3'h6, 32'h0);
        cmp_val("run", 32'h0, {crun, prun});
        $display("test reset values ended");
        d = 8'($urandom);
        run(1'b1, d, 8'h00, 8'h70, 256);
        for (int i = 0; i < 3; i++) look(8'($urandom), 2'd2, d);
        $display("test control memory reset ended");
        host.put(imap_pkg::REG_OPERATION_MODE, 8'h80);
        chk_rd(imap_pkg::REG_OPERATION_MODE, 32'h80);
        a = 8'($urandom);
        v = 8'($urandom);
        c = 8'($urandom);
        run(1'b1, v, a, {4'h7, c[3:0]}, 2);
        run(1'b1, ~v, a ^ 8'h01, 8'h48, 2);
        run(1'b0, 8'h00, a ^ 8'h01, 8'hc8, 2);
        chk_rd(imap_pkg::REG_ACCESS_DATA, {24'h0, ~v});
        look(a, 2'd2, v);
        host.put(imap_pkg::REG_OPERATION_MODE, 8'hc0);
        look(a, 2'd3, {4'h0, c[3:0]});
        cmp_val("run", 32'h3, {crun, prun});
        $display("test initialisation mode ended");
        s = {1'b1, 7'($urandom)};
        for (int i = 0; i < 8; i++) begin
            e = 8'($urandom);
            d = 8'($urandom);
            run(1'b1, e, s, 8'h08, 9);
            run(1'b1, d, {i[0], s[6:0]}, {1'b0, oc[i], 3'h0}, 9);
            e = (e & ~mk[i]) | (d & mk[i]);
            run(1'b0, 8'h00, s, 8'h80, 9);
            chk_rd(imap_pkg::REG_ACCESS_DATA, {24'h0, e});
            look(s, 2'd0, e);
        end
        $display("test sub-timeslot writes ended");
        @(posedge clk);
        rx_s <= s[6:0] ^ 7'h01;
        rx_d <= d;
        rx_v <= 1'b1;
        @(posedge clk);
        rx_v <= 1'b0;
        run(1'b1, ~d, {1'b0, s[6:0] ^ 7'h01}, 8'h08, 9);
        run(1'b0, 8'h00, {1'b0, s[6:0] ^ 7'h01}, 8'h80, 9);
        chk_rd(imap_pkg::REG_ACCESS_DATA, {24'h0, d});
        run(1'b1, e, s, 8'h60, 9);
        look(s, 2'd1, {4'h0, e[3:0]});
        run(1'b0, 8'h00, s, 8'he0, 9);
        chk_rd(imap_pkg::REG_ACCESS_DATA, {28'h0, e[3:0]});
        $display("test downstream and tristate ended");
        v = 8'($urandom);
        host.op(1'b1, v, 8'h00, 8'h68);
        t0 = cyc;
        chk_rd(imap_pkg::REG_STATUS, 32'h1);
        host.put(imap_pkg::REG_ACCESS_DATA, ~v);
        host.idle();
        cmp_time(1035, cyc - t0);
        chk_rd(imap_pkg::REG_ACCESS_DATA, {24'h0, v});
        look(s ^ 8'h01, 2'd1, {4'h0, v[3:0]});
        $display("test tristate fill ended");
        host.put(imap_pkg::REG_OPERATION_MODE, 8'h40);
        v = 8'($urandom);
        run(1'b1, v, 8'($urandom), 8'h08, 256);
        for (int i = 0; i < 3; i++) look({1'b1, 7'($urandom)}, 2'd0, v);
        $display("test sweep mode ended");
        give_verdict();
    end
endmodule
